// ==== verilog/ssb_core.sv ====
// Burst-write SRAM core with write pipeline, scrubbing, sleep and power-off control.
// Overview of operation
// - Burst counter serves four writes per address.
// - New address captured only when load low.
// - Advance ignores selects, write enable; counter increments.
// - Blocked housekeeping drops ready; host gives idle.
// - Scrub walks whole space every half second.
// - Scrubbing runs only while scrub enable high.
// - Code lanes usable without ECC; scrub may alter.
// - Three-stage write path, commit after three writes.
// - Dummy writes advance pipeline without storing data.
// - Sleep request sampled synchronously, data kept.
// - Clock may stop in sleep without loss.
// - Power-off request loses contents, needs reset.
// - Order low gives linear modulo-four stepping.
// - Order high gives start XOR beat count.
// - Reset takes 50us, then 20us clock sync.
// - Ready rises after sync; host waits for it.
// - Order select fixed at power-up, linear/interleaved.
// - With ECC on, code lanes ignored and floating.
// - Clock qualifier high freezes all bus state.
// - Sleep needs deselect; lanes float in sleep/off.
module ssb_core #(
   parameter int ADDR_W = ssb_pkg::MAX_ADDR_W,
   parameter int RESET_COMPLETE_CYC = ssb_pkg::RESET_COMPLETE_CYC,
   parameter int CLOCK_SYNC_CYC = ssb_pkg::CLOCK_SYNC_CYC,
   parameter int SCRUB_PASS_CYC = ssb_pkg::SCRUB_PASS_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Synchronous bus controls
   input wire logic clk_qualify_n,
   input wire logic chip_sel_a_n,
   input wire logic chip_sel_b,
   input wire logic chip_sel_c_n,
   input wire logic addr_advance_load_n,
   input wire logic write_en_n,
   input wire logic write_data_qual_n,
   input wire logic [ADDR_W-1:0] addr,
   // Asynchronous output enable
   input wire logic out_en_n,
   // Data lanes, low 32 and upper code lanes
   input wire logic [ssb_pkg::LANE_W-1:0] dq_in,
   output logic [ssb_pkg::LANE_W-1:0] dq_out,
   output logic [1:0] dq_oe_n,
   // Static configuration
   input wire logic burst_order,
   input wire logic scrub_allow,
   input wire logic ecc_allow,
   // Power control
   input wire logic sleep_req,
   input wire logic shutdown_req,
   // Status
   output logic ready
);
   localparam int DEPTH = 1 << ADDR_W;
   localparam int SCRUB_STEP_RAW = SCRUB_PASS_CYC / DEPTH;
   // A tiny pass length would give a zero step; one cycle is the floor
   localparam int SCRUB_STEP = (SCRUB_STEP_RAW < 1) ? 1 : SCRUB_STEP_RAW;
   // Refuse shapes the logic cannot serve
   if (ADDR_W < 2 || ADDR_W > ssb_pkg::MAX_ADDR_W) begin : g_bad_addr
      $error("ssb_core: ADDR_W out of range");
   end
   if (RESET_COMPLETE_CYC < 1 || CLOCK_SYNC_CYC < 1 || SCRUB_PASS_CYC < 1) begin : g_bad_time
      $error("ssb_core: timing counts must be at least one");
   end
   // Code bits derived from the data lanes
   function automatic logic [ssb_pkg::CODE_W-1:0] code_of(
      input logic [ssb_pkg::DATA_W-1:0] d
   );
      logic [ssb_pkg::CODE_W-1:0] c;
      c = '0;
      for (int i = 0; i < ssb_pkg::CODE_W; i++) begin
         c[i] = d[i] ^ d[(i + 7) % 32] ^ d[(i + 13) % 32] ^ d[31 - i];
      end
      return c;
   endfunction
   // Low address bits of a beat from start value and beat count
   function automatic logic [1:0] beat_low(
      input logic [1:0] start,
      input logic [1:0] cnt,
      input logic interleave
   );
      return interleave ? (start ^ cnt) : 2'(start + cnt);
   endfunction
   ssb_pkg::ssb_state_e state_q, state_d; // Power and init state
   logic [31:0] tmr_q; // Shared delay counter
   logic shut_meta_q, shut_q; // Power-off request synchroniser
   logic order_q; // Burst order caught at reset
   ssb_pkg::ssb_op_e op_q; // Operation of the current burst
   logic [1:0] cnt_q; // Burst beat counter
   logic [ADDR_W-1:0] base_q; // Loaded burst address
   ssb_pkg::ssb_wentry_s wp_q [ssb_pkg::WPIPE_DEPTH]; // Write pipeline
   logic [ssb_pkg::LANE_W-1:0] mem [DEPTH]; // Core array
   logic [ssb_pkg::LANE_W-1:0] dq_out_q; // Read data register
   logic rd_drive_q; // Read data is on the lanes
   logic ready_q; // Ready status
   logic [ADDR_W-1:0] scrub_addr_q; // Next word to scrub
   logic [31:0] scrub_tick_q; // Cycles counted toward the next scrub step
   logic scrub_due_q; // A scrub step is waiting
   logic [4:0] conflict_q; // Cycles a due step has waited
   ssb_pkg::ssb_cmd_s cmd; // Bus pins gathered
   logic accept, load, cont; // Qualified edges
   ssb_pkg::ssb_op_e beat_op; // Operation of this beat
   logic beat_read, beat_write; // Beat kinds
   logic [1:0] next_cnt; // Counter after an advance
   logic [ADDR_W-1:0] beat_addr; // Address of this beat
   logic need_idle; // Housekeeping blocked too long
   logic scrub_go; // Scrub step executes this cycle
   ssb_pkg::ssb_wentry_s new_entry; // Entry pushed by this beat
   // Command decode
   always_comb begin
      cmd.cs_all = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
      cmd.adv_load_n = addr_advance_load_n;
      cmd.write_en_n = write_en_n;
      cmd.data_qual_n = write_data_qual_n;
   end
   // Commands count only when initialised, awake and clock qualified
   // ignore until ready
   assign accept = (state_q == ssb_pkg::ST_RUN) & ~clk_qualify_n;
   assign load = accept & ~cmd.adv_load_n;
   assign cont = accept & cmd.adv_load_n;
   assign next_cnt = 2'(cnt_q + 2'h1);
   // Beat operation and address
   always_comb begin
      beat_op = op_q;
      beat_addr = base_q;
      if (load) begin
         beat_addr = addr;
         if (!cmd.cs_all) begin
            beat_op = ssb_pkg::OP_IDLE;
         end else if (cmd.write_en_n) begin
            beat_op = ssb_pkg::OP_READ;
         end else begin
            beat_op = ssb_pkg::OP_WRITE;
         end
      end else begin
         beat_addr[1:0] = beat_low(base_q[1:0], next_cnt, order_q);
      end
   end
   assign beat_read = (load | cont) & (beat_op == ssb_pkg::OP_READ);
   assign beat_write = (load | cont) & (beat_op == ssb_pkg::OP_WRITE);
   // Burst state: selects and write enable are not looked at on an advance
   always_ff @(posedge core_clk) begin
      if (rst) begin
         op_q <= ssb_pkg::OP_IDLE;
         cnt_q <= ssb_pkg::RESET_BURST_CNT;
         base_q <= '0;
      end else if (load) begin
         op_q <= beat_op;
         cnt_q <= ssb_pkg::RESET_BURST_CNT;
         base_q <= addr;
      end else if (cont) begin
         cnt_q <= next_cnt;
      end
   end
   // Entry formed from the lanes; ECC on replaces the code lanes
   always_comb begin
      new_entry = '0;
      new_entry.valid = ~cmd.data_qual_n;
      new_entry.addr[ADDR_W-1:0] = beat_addr;
      new_entry.data = ecc_allow ? {code_of(dq_in[ssb_pkg::DATA_W-1:0]),
                                    dq_in[ssb_pkg::DATA_W-1:0]} : dq_in;
   end
   // Write pipeline: every write beat, real or dummy, shifts one slot
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < ssb_pkg::WPIPE_DEPTH; i++) begin
            wp_q[i] <= '0;
         end
      end else if (beat_write) begin
         wp_q[0] <= new_entry;
         for (int i = 1; i < ssb_pkg::WPIPE_DEPTH; i++) begin
            wp_q[i] <= wp_q[i-1];
         end
      end
   end
   // Core array: commit of the oldest slot, else a scrub step
   always_ff @(posedge core_clk) begin
      if (beat_write && wp_q[ssb_pkg::WPIPE_DEPTH-1].valid) begin
         mem[wp_q[ssb_pkg::WPIPE_DEPTH-1].addr[ADDR_W-1:0]] <= wp_q[ssb_pkg::WPIPE_DEPTH-1].data;
      end else if (scrub_go) begin
         mem[scrub_addr_q] <= {code_of(mem[scrub_addr_q][ssb_pkg::DATA_W-1:0]),
                               mem[scrub_addr_q][ssb_pkg::DATA_W-1:0]};
      end
   end
   // Read data: newest pipeline copy wins over the array, so no flush is needed
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dq_out_q <= '0;
         rd_drive_q <= 1'b0;
      end else if (state_q != ssb_pkg::ST_RUN) begin
         rd_drive_q <= 1'b0;
      end else if (accept) begin
         rd_drive_q <= beat_read;
         if (beat_read) begin
            dq_out_q <= mem[beat_addr];
            for (int i = ssb_pkg::WPIPE_DEPTH - 1; i >= 0; i--) begin
               if (wp_q[i].valid && wp_q[i].addr[ADDR_W-1:0] == beat_addr) begin
                  dq_out_q <= wp_q[i].data;
               end
            end
         end
      end
   end
   // Lanes float unless a read is out and output enable is low
   // float in sleep and off
   // code lanes float with ECC on
   assign dq_out = dq_out_q;
   assign dq_oe_n[0] = ~(rd_drive_q & ~out_en_n & (state_q == ssb_pkg::ST_RUN));
   assign dq_oe_n[1] = dq_oe_n[0] | ecc_allow;
   // Power-off request crosses in through two flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         shut_meta_q <= 1'b0;
         shut_q <= 1'b0;
      end else begin
         shut_meta_q <= shutdown_req;
         shut_q <= shut_meta_q;
      end
   end
   // Burst order is a power-up strap, caught while reset is held
   always_ff @(posedge core_clk) begin
      if (rst) begin
         order_q <= burst_order;
      end
   end
   // Power and initialisation sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ssb_pkg::ST_RESET_WAIT: begin
            if (tmr_q == 32'(RESET_COMPLETE_CYC - 1)) state_d = ssb_pkg::ST_CLK_SYNC;
         end
         ssb_pkg::ST_CLK_SYNC: begin
            if (tmr_q == 32'(CLOCK_SYNC_CYC - 1)) state_d = ssb_pkg::ST_RUN;
         end
         ssb_pkg::ST_RUN: begin
            if (sleep_req && !cmd.cs_all) state_d = ssb_pkg::ST_SLEEP;
         end
         ssb_pkg::ST_SLEEP: begin
            // nothing here needs a running clock
            if (!sleep_req) state_d = ssb_pkg::ST_SLEEP_REC;
         end
         ssb_pkg::ST_SLEEP_REC: begin
            if (tmr_q == 32'(ssb_pkg::SLEEP_RECOVERY_CYC - 1)) state_d = ssb_pkg::ST_RUN;
         end
         ssb_pkg::ST_OFF: begin
            state_d = ssb_pkg::ST_OFF;
         end
      endcase
      if (shut_q) state_d = ssb_pkg::ST_OFF;
   end
   // State register and its delay counter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= ssb_pkg::ST_RESET_WAIT;
         tmr_q <= '0;
      end else begin
         state_q <= state_d;
         tmr_q <= (state_d != state_q) ? 32'h0 : 32'(tmr_q + 32'h1);
      end
   end
   // Scrub pacing: one word per step gives one pass per nominal period
   // whole space per pass
   assign scrub_go = scrub_due_q & ~beat_read & ~beat_write & accept & scrub_allow;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scrub_addr_q <= '0;
         scrub_tick_q <= '0;
         scrub_due_q <= 1'b0;
      end else if (accept && scrub_allow) begin
         if (scrub_tick_q == 32'(SCRUB_STEP - 1)) begin
            scrub_tick_q <= '0;
         end else begin
            scrub_tick_q <= 32'(scrub_tick_q + 32'h1);
         end
         // Set wins over completion of the previous step
         if (scrub_tick_q == 32'(SCRUB_STEP - 1)) begin
            scrub_due_q <= 1'b1;
         end else if (scrub_go) begin
            scrub_due_q <= 1'b0;
         end
         if (scrub_go) begin
            scrub_addr_q <= ADDR_W'(scrub_addr_q + 1'b1);
         end
      end
   end
   // Waiting time of a due step; too long means an idle cycle is needed
   always_ff @(posedge core_clk) begin
      if (rst || scrub_go || !scrub_due_q) begin
         conflict_q <= '0;
      end else if (accept && conflict_q != 5'(ssb_pkg::CONFLICT_LIMIT_CYC)) begin
         conflict_q <= 5'(conflict_q + 5'h1);
      end
   end
   assign need_idle = (conflict_q == 5'(ssb_pkg::CONFLICT_LIMIT_CYC));
   // Ready rises on the edge that ends clock sync
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ready_q <= ssb_pkg::RESET_READY;
      end else begin
         ready_q <= (state_d == ssb_pkg::ST_RUN || state_d == ssb_pkg::ST_SLEEP ||
                     state_d == ssb_pkg::ST_SLEEP_REC) && !need_idle;
      end
   end
   assign ready = ready_q;
endmodule

// ==== verilog/ssb_pkg.sv ====
// Shared constants, enumerations and carriers of the burst SRAM core.
package ssb_pkg;
   // Clock rate of core_clk
   localparam int CLK_MHZ = 250;
   // Lane layout
   localparam int DATA_W = 32;
   localparam int CODE_W = 20;
   localparam int LANE_W = DATA_W + CODE_W;
   localparam int MAX_ADDR_W = 21;
   // Burst and pipeline shape
   localparam int BURST_LEN = 4;
   localparam int WPIPE_DEPTH = 3;
   // Host-side timing figures, kept for reference by both sides
   localparam int RESET_PULSE_NS = 1000;
   localparam int SLEEP_SETUP_CYC = 2;
   // Device timing figures in their own units
   localparam int RESET_COMPLETE_NS = 50000;
   localparam int CLOCK_SYNC_NS = 20000;
   localparam int SLEEP_RECOVERY_NS = 100;
   localparam int SCRUB_PASS_MS = 500;
   // Derived cycle counts, least times rounded up
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_COMPLETE_CYC = (RESET_COMPLETE_NS * CLK_MHZ + 999) / 1000;
   localparam int CLOCK_SYNC_CYC = (CLOCK_SYNC_NS * CLK_MHZ + 999) / 1000;
   localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_NS * CLK_MHZ + 999) / 1000;
   // Nominal pass length, a typical figure so plain truncation
   localparam int SCRUB_PASS_CYC = SCRUB_PASS_MS * 1000 * CLK_MHZ;
   // Cycles a due scrub step may wait before an idle cycle is asked for
   localparam int CONFLICT_LIMIT_CYC = 16;
   // Values after reset
   localparam logic RESET_READY = 1'b0;
   localparam logic [1:0] RESET_BURST_CNT = 2'h0;
   // Power and initialisation states
   typedef enum logic [2:0] {
      ST_RESET_WAIT, ST_CLK_SYNC, ST_RUN, ST_SLEEP, ST_SLEEP_REC, ST_OFF
   } ssb_state_e;
   // Operation latched at the start of a burst
   typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} ssb_op_e;
   // One slot of the write pipeline
   typedef struct packed {
      logic valid;
      logic [MAX_ADDR_W-1:0] addr;
      logic [LANE_W-1:0] data;
   } ssb_wentry_s;
   // Synchronous command pins taken together
   typedef struct packed {
      logic cs_all;
      logic adv_load_n;
      logic write_en_n;
      logic data_qual_n;
   } ssb_cmd_s;
endpackage

// ==== verification/ssb_core_asserts.sv ====
// Port-level property checker for the burst SRAM core, bound into it.
module ssb_core_asserts #(
   parameter int RESET_COMPLETE_CYC = ssb_pkg::RESET_COMPLETE_CYC,
   parameter int CLOCK_SYNC_CYC = ssb_pkg::CLOCK_SYNC_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bus controls
   input wire logic clk_qualify_n,
   input wire logic chip_sel_a_n,
   input wire logic chip_sel_b,
   input wire logic chip_sel_c_n,
   input wire logic addr_advance_load_n,
   // Modes and power requests
   input wire logic scrub_allow,
   input wire logic ecc_allow,
   input wire logic sleep_req,
   input wire logic shutdown_req,
   // Outputs watched
   input wire logic [ssb_pkg::LANE_W-1:0] dq_out,
   input wire logic [1:0] dq_oe_n,
   input wire logic ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Edge on which ready must first show high
   localparam int RDY_EDGE = RESET_COMPLETE_CYC + CLOCK_SYNC_CYC;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // All three selects active
   wire all_sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
   // Qualified deselect edge that lets a waiting scrub step run
   wire idle_cyc = !clk_qualify_n && !addr_advance_load_n && !all_sel && scrub_allow
      && !sleep_req && !shutdown_req;
   logic [15:0] init_cnt_q; // Edges since reset release, saturating
   logic seen_q; // Ready seen high since reset or power-off
   logic off_q; // Power-off requested since reset
   // Count edges after reset; saturation keeps long runs quiet
   always_ff @(posedge core_clk) begin
      if (rst) begin
         init_cnt_q <= 16'h0000;
      end else if (init_cnt_q != 16'hFFFF) begin
         init_cnt_q <= init_cnt_q + 16'h0001;
      end
   end
   // Ready history, cleared by power-off so its dead time is not judged
   always_ff @(posedge core_clk) begin
      if (rst || shutdown_req) begin
         seen_q <= 1'b0;
      end else if (ready) begin
         seen_q <= 1'b1;
      end
   end
   // Power-off memory, left only by reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         off_q <= 1'b0;
      end else if (shutdown_req) begin
         off_q <= 1'b1;
      end
   end
   property p_init_low;
      (init_cnt_q < RDY_EDGE) |-> !ready && dq_oe_n == 2'b11;
   endproperty
   a_init_low: assert property (p_init_low) else $error("ready or drive before init end");
   property p_ready_rise;
      (init_cnt_q == RDY_EDGE && !off_q) |-> ready;
   endproperty
   a_ready_rise: assert property (p_ready_rise) else $error("ready late after sync");
   property p_off_float;
      shutdown_req [*4] |=> !ready && dq_oe_n == 2'b11;
   endproperty
   a_off_float: assert property (p_off_float) else $error("lanes driven in power-off");
   property p_off_hold;
      $past(off_q, 4) |-> !ready && dq_oe_n == 2'b11;
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("power-off left without reset");
   property p_ecc_float;
      ecc_allow |-> dq_oe_n[1];
   endproperty
   a_ecc_float: assert property (p_ecc_float) else $error("code lanes driven with ecc on");
   property p_sleep_float;
      (sleep_req && !all_sel) [*2] |-> dq_oe_n == 2'b11;
   endproperty
   a_sleep_float: assert property (p_sleep_float) else $error("lanes driven in sleep");
   property p_freeze;
      (clk_qualify_n && !shutdown_req) |=> $stable(dq_out);
   endproperty
   a_freeze: assert property (p_freeze) else $error("read data moved on stalled edge");
   property p_idle_recover;
      (seen_q && !ready && idle_cyc) |=> ##[0:2] ready;
   endproperty
   a_idle_recover: assert property (p_idle_recover) else $error("ready not back after idle");
   c_ready_up: cover property ($rose(ready));
   c_sleep: cover property (sleep_req [*3]);
   c_idle_ask: cover property (seen_q && $fell(ready));
endmodule

bind ssb_core ssb_core_asserts #(
   .RESET_COMPLETE_CYC(RESET_COMPLETE_CYC),
   .CLOCK_SYNC_CYC(CLOCK_SYNC_CYC)
) ssb_core_asserts_inst (
   .core_clk, .rst, .clk_qualify_n, .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n,
   .addr_advance_load_n, .scrub_allow, .ecc_allow, .sleep_req, .shutdown_req,
   .dq_out, .dq_oe_n, .ready
);

// ==== verification/ssb_host_model.sv ====
// Host memory controller model driving the burst SRAM core's pins.
module ssb_host_model #(
   parameter int AW = 4
) (
   // Clock and status from the device
   input wire logic core_clk,
   input wire logic ready,
   // Reset and bus controls
   output logic rst,
   output logic clk_qualify_n,
   output logic chip_sel_a_n,
   output logic chip_sel_b,
   output logic chip_sel_c_n,
   output logic addr_advance_load_n,
   output logic write_en_n,
   output logic write_data_qual_n,
   output logic [AW-1:0] addr,
   output logic out_en_n,
   output logic [ssb_pkg::LANE_W-1:0] dq_in,
   // Static modes and power requests
   output logic burst_order,
   output logic scrub_allow,
   output logic ecc_allow,
   output logic sleep_req,
   output logic shutdown_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pins start quiet: reset held, device deselected
   initial begin
      rst = 1'b1;
      {clk_qualify_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n} = 4'h5;
      {addr_advance_load_n, write_en_n, write_data_qual_n, out_en_n} = 4'h6;
      addr = '0;
      dq_in = '0;
      {burst_order, scrub_allow, ecc_allow, sleep_req, shutdown_req} = 5'h00;
   end
   task automatic reset_dev(input logic order, input int n);
      rst <= 1'b1;
      burst_order <= order;
      repeat (n) @(posedge core_clk);
      rst <= 1'b0;
   endtask
   // Mode, power and output enable pins, changed just after an edge
   task automatic set_modes(input logic scrub, ecc, sleep, shut, oe_n);
      scrub_allow <= scrub;
      ecc_allow <= ecc;
      sleep_req <= sleep;
      shutdown_req <= shut;
      out_en_n <= oe_n;
   endtask
   // One edge; unqualified data lanes toggle so a stale value never passes
   // data qualifier per beat
   task automatic cyc(input logic q_n, ld_n, sel, we_n, wq_n, input logic [AW-1:0] a,
         input logic [ssb_pkg::LANE_W-1:0] d);
      clk_qualify_n <= q_n;
      addr_advance_load_n <= ld_n;
      {chip_sel_a_n, chip_sel_b, chip_sel_c_n} <= sel ? 3'b010 : 3'b101;
      write_en_n <= we_n;
      write_data_qual_n <= wq_n;
      addr <= a;
      dq_in <= wq_n ? ~dq_in : d;
      @(posedge core_clk);
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, '0, '0);
   endtask
   // no commands until ready, bounded wait
   task automatic wait_ready();
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 400) begin
         idle(1);
         n++;
      end
   endtask
endmodule

// ==== verification/ssb_core_tb_top.sv ====
// Self-checking testbench for the burst SRAM core.
module ssb_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = 4; // Small space so scrub passes stay short
   localparam int LW = ssb_pkg::LANE_W;
   logic core_clk = 1'b0;
   logic rst, clk_qualify_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n;
   logic addr_advance_load_n, write_en_n, write_data_qual_n, out_en_n;
   logic burst_order, scrub_allow, ecc_allow, sleep_req, shutdown_req, ready;
   logic [AW-1:0] addr;
   logic [LW-1:0] dq_in, dq_out;
   logic [1:0] dq_oe_n;
   int err_count = 0;
   int checked = 0;
   always #2 core_clk = ~core_clk;
   ssb_host_model #(.AW(AW)) host (
      .core_clk, .ready, .rst, .clk_qualify_n, .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n,
      .addr_advance_load_n, .write_en_n, .write_data_qual_n, .addr, .out_en_n, .dq_in,
      .burst_order, .scrub_allow, .ecc_allow, .sleep_req, .shutdown_req
   );
   // Long init counts shortened; scrub step every 4 cycles
   ssb_core #(.ADDR_W(AW), .RESET_COMPLETE_CYC(20), .CLOCK_SYNC_CYC(10),
         .SCRUB_PASS_CYC(64)) ssb_core_inst (
      .core_clk, .rst, .clk_qualify_n, .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n,
      .addr_advance_load_n, .write_en_n, .write_data_qual_n, .addr, .out_en_n, .dq_in,
      .dq_out, .dq_oe_n, .burst_order, .scrub_allow, .ecc_allow, .sleep_req, .shutdown_req,
      .ready
   );
   // Compare and count
   task automatic chk(input string what, input logic [LW-1:0] seen, input logic [LW-1:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic close_out();
      if (err_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Read load then a deselect edge; only low lanes judged with ecc on
   task automatic rd(input logic [AW-1:0] a, input logic [LW-1:0] exp);
      host.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, a, '0);
      host.idle(1);
      chk("read data", ecc_allow ? LW'(dq_out[31:0]) : dq_out, ecc_allow ? LW'(exp[31:0]) : exp);
      // Output enable high floats both groups; ecc on floats the code lanes
      chk("lane drive", LW'(dq_oe_n), LW'({ecc_allow | out_en_n, out_en_n}));
   endtask
   // Watchdog, far beyond the expected run length
   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      close_out();
   end
   // Main sequence: linear mode, then interleaved after a second reset
   initial begin
      logic [1:0] lo;
      int drops;
      for (int ord = 0; ord < 2; ord++) begin
         host.reset_dev(ord[0], ord == 0 ? 10 : 250);
         host.wait_ready();
         chk("ready after init", LW'(ready), LW'(1'b1));
         // Two bursts; the second has a dummy third beat, the first a stall
         for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
               if (p == 0 && k == 2) begin
                  // frozen edge with a would-be deselect
                  host.cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, '1);
               end
               host.cyc(1'b0, k != 0, k == 0, k != 0, p == 1 && k == 2, k == 0 ? 4'h5 : 4'hA,
                  {4'(p + 10), 20'h0, 24'h5A5A5A, 4'(k)});
            end
         end
         // dummy burst pushes earlier beats to the array
         for (int k = 0; k < 4; k++) host.cyc(1'b0, k != 0, k == 0, 1'b0, 1'b1, 4'hC, '0);
         for (int k = 0; k < 4; k++) begin
            lo = ord[0] ? 2'h1 ^ 2'(k) : 2'h1 + 2'(k);
            rd({2'h1, lo}, {4'(k == 2 ? 10 : 11), 20'h0, 24'h5A5A5A, 4'(k)});
         end
         host.set_modes(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
         rd(4'h5, {4'hB, 20'h0, 24'h5A5A5A, 4'h0});
         // Output enable high: data still registered, lanes float
         host.set_modes(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
         rd(4'h5, {4'hB, 20'h0, 24'h5A5A5A, 4'h0});
         host.set_modes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         host.idle(2);
         host.set_modes(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
         host.idle(3);
         chk("sleep lanes", LW'(dq_oe_n), LW'(2'b11));
         host.set_modes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         host.idle(26);
         rd(4'h5, {4'hB, 20'h0, 24'h5A5A5A, 4'h0});
         drops = 0;
         for (int i = 0; i < 40; i++) begin
            host.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h5, '0);
            drops += int'(ready !== 1'b1);
         end
         chk("drops without scrub", LW'(drops), '0);
         host.set_modes(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
         drops = 0;
         while (ready === 1'b1 && drops < 100) begin
            host.cyc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h5, '0);
            drops++;
         end
         chk("ready under load", LW'(ready), '0);
         host.idle(4);
         chk("ready after idle", LW'(ready), LW'(1'b1));
         host.set_modes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         if (ord == 0) begin
            host.set_modes(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
            host.idle(5);
            chk("off lanes", LW'(dq_oe_n), LW'(2'b11));
            host.set_modes(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            host.idle(40);
            chk("ready after off", LW'(ready), '0);
         end
      end
      close_out();
   end
endmodule
